// >>> core/accessory_ctrl.sv
// top: axi4-lite registers, factory accessory detection and switch control
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - charge: battery 10, host on, bus valid, no error, no detect
// - auto-stop plus expired 30 min timer stops charging
// - type 000: force only; 001: force or chargepump bit clear
// - detection enabled out of reset
// - order: factory ids, headset, usb cable, charger
// - headset: 1M or button id, no bus power
// - usb cable: id open, type 001 or 010
// - charger: type 011 to 110
// - factory ids: pin low, route usb or uart
// - other ids: pin released, lines open unless headset or usb cable
// - detect off: host sets switches
// - codes 100-111 leave a line open
// - shunt bit grounds both audio inputs
// - removal detect: video stop or load loss raises flag
// - adc off forces id reading to ones
// - flag read clears flags, releases interrupt
module accessory_ctrl
  import gate_pkg::*;
#(
  parameter logic [gate_pkg::TIMER_W-1:0] TIMER_CYCLES =
    gate_pkg::CHG_TIMER_CYCLES
)(
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic                      ce,
  // axi4-lite slave
  input  wire logic [gate_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [gate_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // analog side status
  input  wire gate_pkg::charger_status_t chg_status,
  input  wire logic [4:0]                id_line_input,
  input  wire logic                      adc_low_flag,
  input  wire logic                      bus_power_pin,
  input  wire logic                      video_signal_present,
  input  wire logic                      video_load_present,
  // switch and charger controls
  output gate_pkg::line_switch_t         connector_neg_line,
  output gate_pkg::line_switch_t         connector_pos_line,
  output logic                           factory_output_pin_o,
  output logic                           factory_output_pin_oe,
  output logic                           click_pop_shunt_enable,
  output logic                           id_video_switch,
  output logic                           adc_enable,
  output logic                           charge_enable,
  output logic                           int_n
);
  typedef enum logic [2:0] {
    ST_MANUAL = 3'b001,
    ST_EVAL   = 3'b010,
    ST_HOLD   = 3'b100
  } det_state_t;

  typedef struct packed {
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    logic [31:0]      ctrl;
    logic [31:0]      chg;
    logic [31:0]      mask;
    logic [FLG_W-1:0] flags;
    det_state_t       det;
    logic [2:0]       acc;
    logic [2:0]       auto_neg;
    logic [2:0]       auto_pos;
    logic             auto_fact_low;
    logic [4:0]       prev_id;
    logic [2:0]       prev_type;
    logic             prev_vsig;
    logic             prev_vload;
    logic             prev_chg;
    line_switch_t     neg;
    line_switch_t     pos;
    logic             fact_oe;
    logic             int_n;
  } top_state_t;

  top_state_t st_reg;
  top_state_t st_next;
  logic       chg_on;
  logic       chg_expired;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // select code to one-hot input connection; high codes connect nothing
  function automatic logic [3:0] sw_decode(input logic [2:0] sel);
    sw_decode = '0;
    if (!sel[SW_HIZ_BIT])
      sw_decode[sel[1:0]] = 1'b1;
  endfunction

  // byte-lane merge of a write into a register
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb,
                                         input logic [31:0] wmask);
    wmerge = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        wmerge[i*8 +: 8] = data[i*8 +: 8];
    end
    wmerge = (wmerge & wmask) | (old & ~wmask);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // charger gate
  charge_gate #(
    .TIMER_CYCLES (TIMER_CYCLES)
  ) u_gate (
    .clk                   (clk),
    .resetn                (resetn),
    .ce                    (ce),
    .stat                  (chg_status),
    .ctrl                  ('{host_charge_enable: st_reg.chg[CHG_HOST_EN],
                              force_charge:       st_reg.chg[CHG_FORCE],
                              auto_stop_enable:   st_reg.chg[CHG_AUTO_STOP]}),
    .charging_enabled_flag (chg_on),
    .timer_expired         (chg_expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    logic [4:0]       id_eff;
    logic [2:0]       ctyp;
    logic [FLG_W-1:0] set;
    logic [FLG_W-1:0] clr;
    logic [31:0]      status;
    logic             wr_go;
    logic             rd_go;
    logic [2:0]       nsel;
    logic [2:0]       psel;
    id_eff = '0;
    ctyp   = '0;
    set    = '0;
    clr    = '0;
    status = '0;
    wr_go  = 1'b0;
    rd_go  = 1'b0;
    nsel   = '0;
    psel   = '0;
    st_next = st_reg;

    // id reading as seen by detection and software
    id_eff = st_reg.ctrl[CTL_ADC_EN] ? id_line_input : ID_OPEN;
    ctyp   = chg_status.charger_type_field;

    // event sources
    set[FLG_ID]   = (id_eff != st_reg.prev_id);
    set[FLG_TYPE] = (ctyp != st_reg.prev_type);
    set[FLG_CHG]  = (chg_on != st_reg.prev_chg);
    set[FLG_VID_RM] = st_reg.ctrl[CTL_VID_RM_EN]
      && ((st_reg.prev_vsig && !video_signal_present)
       || (st_reg.prev_vload && !video_load_present));
    st_next.prev_id    = id_eff;
    st_next.prev_type  = ctyp;
    st_next.prev_chg   = chg_on;
    st_next.prev_vsig  = video_signal_present;
    st_next.prev_vload = video_load_present;

    // status word
    status[4:0]   = id_eff;
    status[5]     = adc_low_flag;
    status[10:8]  = ctyp;
    status[11]    = chg_status.bus_voltage_valid;
    status[12]    = chg_on;
    status[13]    = chg_expired;
    status[15:14] = chg_status.battery_presence_code;
    status[16]    = chg_status.charge_error_flag;
    status[17]    = chg_status.charger_detect_running;
    status[18]    = bus_power_pin;
    status[22:20] = st_reg.acc;
    status[26:24] = st_reg.det;

    // write channel: address and data taken together
    st_next.awready = 1'b0;
    st_next.wready  = 1'b0;
    if (st_reg.bvalid && s_axi_bready)
      st_next.bvalid = 1'b0;
    wr_go = st_reg.awready && st_reg.wready;
    if (s_axi_awvalid && s_axi_wvalid && !st_reg.bvalid && !wr_go)
    begin
      st_next.awready = 1'b1;
      st_next.wready  = 1'b1;
    end
    if (wr_go)
    begin
      st_next.bvalid = 1'b1;
      st_next.bresp  = RESP_OKAY;
      case (s_axi_awaddr)
        CTRL_OFFS: st_next.ctrl = wmerge(st_reg.ctrl, s_axi_wdata,
                                         s_axi_wstrb, CTRL_WMASK);
        CHG_OFFS:  st_next.chg  = wmerge(st_reg.chg, s_axi_wdata,
                                         s_axi_wstrb, CHG_WMASK);
        MASK_OFFS: st_next.mask = wmerge(st_reg.mask, s_axi_wdata,
                                         s_axi_wstrb, MASK_RESET);
        STAT_OFFS: ;
        FLAG_OFFS: ;
        default:   st_next.bresp = RESP_SLVERR;
      endcase
    end

    // read channel
    st_next.arready = 1'b0;
    if (st_reg.rvalid && s_axi_rready)
      st_next.rvalid = 1'b0;
    rd_go = st_reg.arready;
    if (s_axi_arvalid && !st_reg.rvalid && !rd_go)
      st_next.arready = 1'b1;
    if (rd_go)
    begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = RESP_OKAY;
      st_next.rdata  = '0;
      case (s_axi_araddr)
        CTRL_OFFS: st_next.rdata = st_reg.ctrl;
        CHG_OFFS:  st_next.rdata = st_reg.chg;
        STAT_OFFS: st_next.rdata = status;
        MASK_OFFS: st_next.rdata = st_reg.mask;
        FLAG_OFFS:
        begin
          st_next.rdata[FLG_W-1:0] = st_reg.flags;
          clr = '1;
        end
        default:   st_next.rresp = RESP_SLVERR;
      endcase
    end

    // sticky flags: a new event wins over the read clear
    st_next.flags = (st_reg.flags & ~clr) | set;
    st_next.int_n = ~|(st_next.flags & ~st_reg.mask[FLG_W-1:0]);

    // factory detection state machine
    case (st_reg.det)
      ST_MANUAL:
      begin
        if (st_reg.ctrl[CTL_ACC_DET])
          st_next.det = ST_EVAL;
      end
      ST_EVAL:
      begin
        st_next.det           = ST_HOLD;
        st_next.acc           = ACC_NONE;
        st_next.auto_neg      = SW_HIZ;
        st_next.auto_pos      = SW_HIZ;
        st_next.auto_fact_low = 1'b0;
        if (id_eff == ID_FUSB_A || id_eff == ID_FUSB_B)
        begin
          st_next.acc           = ACC_FACTORY;
          st_next.auto_neg      = SW_USB;
          st_next.auto_pos      = SW_USB;
          st_next.auto_fact_low = 1'b1;
        end
        else if (id_eff == ID_FUART_A || id_eff == ID_FUART_B)
        begin
          st_next.acc           = ACC_FACTORY;
          st_next.auto_neg      = SW_UART;
          st_next.auto_pos      = SW_UART;
          st_next.auto_fact_low = 1'b1;
        end
        else if ((id_eff == ID_AUDIO_1M || (id_eff >= ID_BTN_LO
                 && id_eff <= ID_BTN_HI)) && !bus_power_pin)
        begin
          st_next.acc      = ACC_AUDIO;
          st_next.auto_neg = SW_AUDIO;
          st_next.auto_pos = SW_AUDIO;
        end
        else if (id_eff == ID_OPEN
                 && (ctyp == TYPE_SDP || ctyp == TYPE_CDP))
        begin
          st_next.acc      = ACC_USB;
          st_next.auto_neg = SW_USB;
          st_next.auto_pos = SW_USB;
        end
        else if (ctyp >= TYPE_DCP_LO && ctyp <= TYPE_DCP_HI)
          st_next.acc = ACC_CHARGER;
        if (!st_reg.ctrl[CTL_ACC_DET])
          st_next.det = ST_MANUAL;
      end
      ST_HOLD:
      begin
        if (!st_reg.ctrl[CTL_ACC_DET])
          st_next.det = ST_MANUAL;
        else if (set[FLG_ID] || set[FLG_TYPE])
          st_next.det = ST_EVAL;
      end
      default:
        st_next.det = ST_EVAL;
    endcase

    // switch outputs: automatic result or host selection
    if (st_reg.det == ST_MANUAL)
    begin
      nsel = st_reg.ctrl[CTL_NEG_LO +: 3];
      psel = st_reg.ctrl[CTL_POS_LO +: 3];
      st_next.fact_oe = !st_reg.ctrl[CTL_FACT_LOW];
    end
    else
    begin
      nsel = st_reg.auto_neg;
      psel = st_reg.auto_pos;
      st_next.fact_oe = !st_reg.auto_fact_low;
    end
    st_next.neg.select  = nsel;
    st_next.neg.connect = sw_decode(nsel);
    st_next.pos.select  = psel;
    st_next.pos.connect = sw_decode(psel);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg           <= '0;
      st_reg.ctrl      <= CTRL_RESET;
      st_reg.chg       <= CHG_RESET;
      st_reg.mask      <= MASK_RESET;
      st_reg.det       <= ST_EVAL;
      st_reg.acc       <= ACC_NONE;
      st_reg.auto_neg  <= SW_HIZ;
      st_reg.auto_pos  <= SW_HIZ;
      st_reg.prev_id   <= ID_OPEN;
      st_reg.neg       <= '{connect: 4'h0, select: SW_HIZ};
      st_reg.pos       <= '{connect: 4'h0, select: SW_HIZ};
      st_reg.fact_oe   <= 1'b1;
      st_reg.int_n     <= 1'b1;
    end
    else if (ce)
      st_reg <= st_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  assign s_axi_awready          = st_reg.awready;
  assign s_axi_wready           = st_reg.wready;
  assign s_axi_bvalid           = st_reg.bvalid;
  assign s_axi_bresp            = st_reg.bresp;
  assign s_axi_arready          = st_reg.arready;
  assign s_axi_rvalid           = st_reg.rvalid;
  assign s_axi_rresp            = st_reg.rresp;
  assign s_axi_rdata            = st_reg.rdata;
  assign connector_neg_line     = st_reg.neg;
  assign connector_pos_line     = st_reg.pos;
  assign factory_output_pin_o   = st_reg.auto_fact_low & 1'b0;  // drives low
  assign factory_output_pin_oe  = st_reg.fact_oe;   // low while pulling down
  assign click_pop_shunt_enable = st_reg.ctrl[CTL_SHUNT];
  assign id_video_switch        = st_reg.ctrl[CTL_ID_VIDEO];
  assign adc_enable             = st_reg.ctrl[CTL_ADC_EN];
  assign charge_enable          = chg_on;
  assign int_n                  = st_reg.int_n;
endmodule
`default_nettype wire

// >>> core/gate_pkg.sv
// shared constants, register map and carrier types for the charger gate block
package gate_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFFS     = 8'h00;
  localparam logic [7:0] CHG_OFFS      = 8'h04;
  localparam logic [7:0] STAT_OFFS     = 8'h08;
  localparam logic [7:0] FLAG_OFFS     = 8'h0c;
  localparam logic [7:0] MASK_OFFS     = 8'h10;
  localparam int         ADDR_W        = 8;
  // control register fields
  localparam int CTL_ACC_DET    = 0;
  localparam int CTL_ADC_EN     = 1;
  localparam int CTL_SHUNT      = 2;
  localparam int CTL_VID_RM_EN  = 3;
  localparam int CTL_ID_VIDEO   = 4;
  localparam int CTL_FACT_LOW   = 5;
  localparam int CTL_NEG_LO     = 8;
  localparam int CTL_POS_LO     = 12;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_4403;
  localparam logic [31:0] CTRL_WMASK  = 32'h0000_773f;
  // charger control fields
  localparam int CHG_HOST_EN    = 0;
  localparam int CHG_FORCE      = 1;
  localparam int CHG_AUTO_STOP  = 2;
  localparam logic [31:0] CHG_RESET   = 32'h0000_0004;
  localparam logic [31:0] CHG_WMASK   = 32'h0000_0007;
  // interrupt flags
  localparam int FLG_ID         = 0;
  localparam int FLG_TYPE       = 1;
  localparam int FLG_VID_RM     = 2;
  localparam int FLG_CHG        = 3;
  localparam int FLG_W          = 4;
  localparam logic [31:0] MASK_RESET  = 32'h0000_000f;
  // axi responses
  localparam logic [1:0] RESP_OKAY    = 2'b00;
  localparam logic [1:0] RESP_SLVERR  = 2'b10;
  // battery, charger-type and id codes
  localparam logic [1:0] BAT_PRESENT  = 2'b10;
  localparam logic [2:0] TYPE_NONE    = 3'b000;
  localparam logic [2:0] TYPE_SDP     = 3'b001;
  localparam logic [2:0] TYPE_CDP     = 3'b010;
  localparam logic [2:0] TYPE_DCP_LO  = 3'b011;
  localparam logic [2:0] TYPE_DCP_HI  = 3'b110;
  localparam logic [4:0] ID_FUSB_A    = 5'h18;
  localparam logic [4:0] ID_FUSB_B    = 5'h19;
  localparam logic [4:0] ID_FUART_A   = 5'h1c;
  localparam logic [4:0] ID_FUART_B   = 5'h1d;
  localparam logic [4:0] ID_AUDIO_1M  = 5'h1e;
  localparam logic [4:0] ID_OPEN      = 5'h1f;
  localparam logic [4:0] ID_BTN_LO    = 5'h01;
  localparam logic [4:0] ID_BTN_HI    = 5'h0d;
  // switch-select codes; bit 2 set means high impedance
  localparam logic [2:0] SW_USB       = 3'b000;
  localparam logic [2:0] SW_AUDIO     = 3'b001;
  localparam logic [2:0] SW_UART      = 3'b010;
  localparam logic [2:0] SW_HIZ       = 3'b100;
  localparam int         SW_HIZ_BIT   = 2;
  // accessory classes reported in status
  localparam logic [2:0] ACC_NONE     = 3'd0;
  localparam logic [2:0] ACC_FACTORY  = 3'd1;
  localparam logic [2:0] ACC_AUDIO    = 3'd2;
  localparam logic [2:0] ACC_USB      = 3'd3;
  localparam logic [2:0] ACC_CHARGER  = 3'd4;
  // charge timer
  localparam int          TIMER_W        = 42;
  localparam longint      CHG_TIMER_MIN  = 30;
  localparam longint      CLK_PERIOD_PS  = 4000;
  localparam logic [TIMER_W-1:0] CHG_TIMER_CYCLES =
    TIMER_W'(CHG_TIMER_MIN * 64'd60 * 64'd1000000000000 / CLK_PERIOD_PS);

  // analog status bits feeding the charger gate
  typedef struct packed {
    logic [1:0] battery_presence_code;
    logic       bus_voltage_valid;
    logic       charge_error_flag;
    logic       charger_detect_running;
    logic [2:0] charger_type_field;
    logic       usb_chargepump_int_bit;
  } charger_status_t;

  // host charge controls
  typedef struct packed {
    logic host_charge_enable;
    logic force_charge;
    logic auto_stop_enable;
  } charger_ctrl_t;

  // one connector line: one-hot input connection (usb, audio, uart, aux)
  typedef struct packed {
    logic [3:0] connect;
    logic [2:0] select;
  } line_switch_t;
endpackage

// >>> core/charge_gate.sv
// charger enable decision with the auto-stop charge timer
`timescale 1ns/100ps
`default_nettype none
module charge_gate
  import gate_pkg::*;
#(
  parameter logic [gate_pkg::TIMER_W-1:0] TIMER_CYCLES =
    gate_pkg::CHG_TIMER_CYCLES
)(
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     ce,
  input  wire gate_pkg::charger_status_t stat,
  input  wire gate_pkg::charger_ctrl_t   ctrl,
  output logic                          charging_enabled_flag,
  output logic                          timer_expired
);
  typedef struct packed {
    logic [TIMER_W-1:0] timer;
    logic               on;
    logic               expired;
  } gate_state_t;

  gate_state_t st_reg;
  gate_state_t st_next;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    logic base_ok;
    logic type_ok;
    base_ok = 1'b0;
    type_ok = 1'b0;
    st_next = st_reg;
    base_ok = (stat.battery_presence_code == BAT_PRESENT)
            && ctrl.host_charge_enable && stat.bus_voltage_valid
            && !stat.charge_error_flag
            && !stat.charger_detect_running;
    if (stat.charger_type_field == TYPE_NONE)
      type_ok = ctrl.force_charge;
    else if (stat.charger_type_field == TYPE_SDP)
      type_ok = ctrl.force_charge
              || !stat.usb_chargepump_int_bit;
    else
      type_ok = 1'b1;
    // timer runs while charge is allowed, restarts when it is not
    if (!(base_ok && type_ok))
      st_next.timer = '0;
    else if (st_reg.timer != TIMER_CYCLES)
      st_next.timer = st_reg.timer + TIMER_W'(1);
    st_next.expired = (st_next.timer == TIMER_CYCLES);
    st_next.on = base_ok && type_ok
               && !(ctrl.auto_stop_enable && st_next.expired);
  end

  // state register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      st_reg <= '0;
    else if (ce)
      st_reg <= st_next;
  end

  assign charging_enabled_flag = st_reg.on;
  assign timer_expired         = st_reg.expired;
endmodule
`default_nettype wire

// >>> test/accessory_ctrl_properties.sv
// port checks for the accessory and charger control block
`timescale 1ns/100ps
`default_nettype none
module accessory_ctrl_properties
  import gate_pkg::*;
(
  input wire logic                         clk,
  input wire logic                         resetn,
  input wire logic                         s_axi_awready,
  input wire logic                         s_axi_wready,
  input wire logic                         s_axi_bvalid,
  input wire logic                         s_axi_arvalid,
  input wire logic                         s_axi_arready,
  input wire logic [gate_pkg::ADDR_W-1:0]  s_axi_araddr,
  input wire logic                         s_axi_rvalid,
  input wire logic                         s_axi_rready,
  input wire gate_pkg::charger_status_t    chg_status,
  input wire gate_pkg::line_switch_t       connector_neg_line,
  input wire gate_pkg::line_switch_t       connector_pos_line,
  input wire logic                         factory_output_pin_o,
  input wire logic                         factory_output_pin_oe,
  input wire logic                         charge_enable,
  input wire logic                         int_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  //////////////////////////////////////////////////////////////////////
  // charging needs battery, bus, no error and no detection one edge back
  property p_chg_cause;
    charge_enable |-> $past(chg_status.battery_presence_code == BAT_PRESENT
      && chg_status.bus_voltage_valid && !chg_status.charge_error_flag
      && !chg_status.charger_detect_running);
  endproperty
  a_chg_cause: assert property (p_chg_cause) else $error("charge cause");
  property p_neg_open; connector_neg_line.select[SW_HIZ_BIT] |-> connector_neg_line.connect == 4'h0; endproperty
  a_neg_open: assert property (p_neg_open) else $error("neg not open");
  property p_pos_open; connector_pos_line.select[SW_HIZ_BIT] |-> connector_pos_line.connect == 4'h0; endproperty
  a_pos_open: assert property (p_pos_open) else $error("pos not open");
  property p_fact_low; !factory_output_pin_oe |-> !factory_output_pin_o; endproperty
  a_fact_low: assert property (p_fact_low) else $error("factory pin");
  // a taken flag read releases the interrupt within three edges
  property p_flag_clr;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == FLAG_OFFS |-> ##[1:3] int_n;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("int held");
  property p_wr_ans; s_axi_awready |-> s_axi_wready ##1 s_axi_bvalid; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer");
  property p_rd_ans; s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer");
  property p_rd_end; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rd_end: assert property (p_rd_end) else $error("read end");
endmodule
bind accessory_ctrl accessory_ctrl_properties checker_i (.*);
`default_nettype wire

// >>> test/accessory_model.sv
// behavioural model of the accessory plugged into the connector
`timescale 1ns/100ps
`default_nettype none
module accessory_model
(
  input  wire logic [4:0] id_value,
  input  wire logic       supply_ok,
  input  wire logic       video_on,
  output logic [4:0]      id_line_input,
  output logic            adc_low_flag,
  output logic            bus_power_pin,
  output logic            video_signal_present,
  output logic            video_load_present
);
  // id reading; low flag clear only for a grounded id pin
  always_comb
  begin
    id_line_input = id_value;
    adc_low_flag = (id_value != 5'h00) || video_on;
    bus_power_pin = supply_ok;
    video_signal_present = video_on;
    video_load_present = video_on;
  end
endmodule
`default_nettype wire

// >>> test/accessory_ctrl_test.sv
// self-checking bench for the accessory and charger control block
`timescale 1ns/100ps
`default_nettype none
module accessory_ctrl_test;
  import gate_pkg::*;
  localparam int TMR = 40;
  // detection: id[13:9] type[8:6] supply[5] connect[4:1] oe[0]
  localparam logic [13:0] DET [15] = '{14'h31a2, 14'h33a2, 14'h38e8,
    14'h3ae8, 14'h3401, 14'h3c05, 14'h0205, 14'h1a05, 14'h0221, 14'h3e63,
    14'h3ea3, 14'h3ee1, 14'h3f21, 14'h3f61, 14'h3fa1};
  // charge: host[11] force[10] status[9:1] expected[0]
  localparam logic [11:0] CHG [11] = '{12'ha85, 12'h884, 12'ha04, 12'hac4,
    12'haa4, 12'ha80, 12'ha86, 12'ha8d, 12'he81, 12'he87, 12'h284};
  logic clk = '0, resetn = '0, awvalid = '0, wvalid = '0;
  logic bready = '0, arvalid = '0, rready = '0, supply_ok = '0;
  logic video_on = '0, awready, wready, bvalid, arready, rvalid, fo, oe;
  logic shunt, idv, adc_en, chg_en, int_n, adc_low_flag, bus_power_pin;
  logic video_signal_present, video_load_present;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [4:0] id_value = 5'h1f, id_line_input;
  charger_status_t st = '0;
  line_switch_t neg, pos;
  int fail_count = 0, tests_run = 0, cycles = 0;
  always #2 clk = ~clk;
  accessory_ctrl #(.TIMER_CYCLES(TIMER_W'(TMR))) DUT (.clk,
    .resetn, .ce(1'b1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .chg_status(st), .id_line_input,
    .adc_low_flag, .bus_power_pin, .video_signal_present,
    .video_load_present, .connector_neg_line(neg),
    .connector_pos_line(pos), .factory_output_pin_o(fo),
    .factory_output_pin_oe(oe), .click_pop_shunt_enable(shunt),
    .id_video_switch(idv), .adc_enable(adc_en), .charge_enable(chg_en),
    .int_n);
  accessory_model far (.*);
  //////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bus write: hold each channel until taken, bready until bvalid
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    check({30'h0, bresp}, {30'h0, RESP_OKAY});
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task test_regs;
    rd(CTRL_OFFS, d, r);
    check(d, CTRL_RESET);
    rd(CHG_OFFS, d, r);
    check(d, CHG_RESET);
    rd(8'h14, d, r);
    check({r, d[29:0]}, {RESP_SLVERR, 30'h0});
    $display("test_regs done");
  endtask
  task test_detect;
    foreach (DET[i])
    begin
      id_value <= DET[i][13:9];
      st.charger_type_field <= DET[i][8:6];
      st.bus_voltage_valid <= DET[i][5];
      supply_ok <= DET[i][5];
      repeat (8) @(posedge clk);
      check({23'h0, oe, neg.connect, pos.connect}, {23'h0, DET[i][0],
        DET[i][4:1], DET[i][4:1]});
    end
    $display("test_detect done");
  endtask
  task test_manual;
    wr(CTRL_OFFS, 32'h5214);
    id_value <= ID_FUSB_A;
    repeat (8) @(posedge clk);
    check({20'h0, oe, neg.connect, pos.connect, shunt, idv, adc_en},
      {20'h0, 1'b1, 4'h4, 4'h0, 3'b110});
    rd(STAT_OFFS, d, r);
    check({26'h0, d[5:0]}, {26'h0, 1'b1, ID_OPEN});
    wr(CTRL_OFFS, CTRL_RESET);
    $display("test_manual done");
  endtask
  task test_charge;
    foreach (CHG[i])
    begin
      wr(CHG_OFFS, {29'h0, 1'b0, CHG[i][10], CHG[i][11]});
      st <= CHG[i][9:1];
      repeat (4) @(posedge clk);
      check({31'h0, chg_en}, {31'h0, CHG[i][0]});
    end
    st <= 9'h142;
    wr(CHG_OFFS, 32'h5);
    repeat (10) @(posedge clk);
    check({31'h0, chg_en}, 32'h1);
    repeat (TMR) @(posedge clk);
    check({31'h0, chg_en}, 32'h0);
    wr(CHG_OFFS, 32'h1);
    repeat (4) @(posedge clk);
    check({31'h0, chg_en}, 32'h1);
    $display("test_charge done");
  endtask
  task test_flags;
    video_on <= 1'b1;
    wr(CTRL_OFFS, 32'h4418);
    wr(MASK_OFFS, 32'h0);
    rd(FLAG_OFFS, d, r);
    video_on <= 1'b0;
    repeat (4) @(posedge clk);
    check({31'h0, int_n}, 32'h0);
    rd(FLAG_OFFS, d, r);
    check(d, 32'h4);
    repeat (3) @(posedge clk);
    check({31'h0, int_n}, 32'h1);
    rd(FLAG_OFFS, d, r);
    check(d, 32'h0);
    wr(CTRL_OFFS, CTRL_RESET);
    $display("test_flags done");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // cycle ceiling against a hung handshake
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      complete_run;
    end
  end
  initial
  begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    test_regs;
    test_detect;
    test_manual;
    test_charge;
    test_flags;
    complete_run;
  end
endmodule
`default_nettype wire
